/* hw/readout_regs.svh */
// Purpose: Register indexes, reset values and timing counts of the signal-path readout.
// Assumes: System clock of 100 MHz.
// Notes: Register indexes are the values carried in a read command frame.
`ifndef READOUT_REGS_SVH
`define READOUT_REGS_SVH

`define RO_IDX_TEMP 3'h0
`define RO_IDX_COMP_A 3'h1
`define RO_IDX_COMP_B 3'h2
`define RO_IDX_CORR_A 3'h3
`define RO_IDX_CORR_B 3'h4
`define RO_IDX_POS 3'h5
`define RO_IDX_OUTEQ 3'h6
`define RO_IDX_MAG 3'h7
`define RO_RESET 16'h0000
`define RO_READ_OPCODE 5'h15
`define RO_CODE_MAX 16'h7FFF

`define CLK_PERIOD_NS 10
`define CLK_HZ 100000000
`define SAMPLE_HZ 8000
`define SAMPLE_CYC (`CLK_HZ / `SAMPLE_HZ)

// Least low time of a one bit, least idle time that ends a frame, and reply bit time.
`define PIN_LONG_NS 20000
`define PIN_LONG_CYC ((`PIN_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_GAP_NS 40000
`define PIN_GAP_CYC ((`PIN_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_BIT_NS 20000
`define PIN_BIT_CYC (`PIN_BIT_NS / `CLK_PERIOD_NS)

// Temperature code = 100 + (raw + 2560) * 119 / 128, raw in 1/64 degree Celsius.
`define TEMP_CODE_LO 16'h0064
`define TEMP_RAW_OFS 2560
`define TEMP_SLOPE_NUM 119
`define TEMP_SLOPE_SH 7

`define CORDIC_STEPS 15
`define ANGLE_HALF 16'h4000

`endif

/* hw/readout_pkg.sv */
// Purpose: Types shared by the signal-path readout.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: Constants live in readout_regs.svh.
package readout_pkg;
	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} field_vec_t;

	typedef struct packed {
		logic signed [15:0] gain_a;
		logic signed [15:0] gain_b;
		logic signed [15:0] phase;
		logic signed [15:0] offset_a;
		logic signed [15:0] offset_b;
		logic [15:0] hyst;
	} path_cfg_t;

	typedef enum logic [1:0] {VAR_XY, VAR_YZ, VAR_XZ} variant_t;
	typedef enum logic {PIN_RX, PIN_REPLY} pin_state_t;
endpackage

/* hw/angle_cordic.sv */
// Purpose: Iterative vectoring CORDIC giving angle and scaled amplitude of two channels.
// Assumes: Start is a one-cycle pulse; inputs stay stable until done.
// Notes: A full turn is 32768 angle codes; the amplitude carries the CORDIC gain of about 1.6.
`timescale 1ns/10ps
`default_nettype none
`include "readout_regs.svh"
module angle_cordic (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_start,
	input wire logic signed [15:0] i_a,
	input wire logic signed [15:0] i_b,
	output logic o_done,
	output logic [14:0] o_angle,
	output logic [15:0] o_amp
);
	logic signed [18:0] x_r, y_r;
	logic [15:0] z_r;
	logic [3:0] step_r;
	logic busy_r;
	logic fin_r;
	wire logic neg_x = i_a[15];
	wire logic signed [18:0] xs = x_r >>> step_r;
	wire logic signed [18:0] ys = y_r >>> step_r;

	function automatic logic [15:0] atan_code(input logic [3:0] i);
		case (i)
			4'h0: atan_code = 16'h1000;
			4'h1: atan_code = 16'h0972;
			4'h2: atan_code = 16'h04FE;
			4'h3: atan_code = 16'h0289;
			4'h4: atan_code = 16'h0146;
			4'h5: atan_code = 16'h00A3;
			4'h6: atan_code = 16'h0051;
			4'h7: atan_code = 16'h0029;
			4'h8: atan_code = 16'h0014;
			4'h9: atan_code = 16'h000A;
			4'hA: atan_code = 16'h0005;
			4'hB: atan_code = 16'h0003;
			4'hC: atan_code = 16'h0001;
			4'hD: atan_code = 16'h0001;
			default: atan_code = 16'h0000;
		endcase
	endfunction

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			busy_r <= 1'b0;
			fin_r <= 1'b0;
			o_done <= 1'b0;
			step_r <= 4'h0;
			x_r <= 19'sh0;
			y_r <= 19'sh0;
			z_r <= 16'h0000;
			o_angle <= 15'h0000;
			o_amp <= 16'h0000;
		end else begin
			// Done follows the last step by one cycle so that it rises together with the new results.
			fin_r <= 1'b0;
			o_done <= fin_r;
			if (i_start) begin
				busy_r <= 1'b1;
				step_r <= 4'h0;
				x_r <= neg_x ? -19'(i_a) : 19'(i_a);
				y_r <= neg_x ? -19'(i_b) : 19'(i_b);
				z_r <= neg_x ? `ANGLE_HALF : 16'h0000;
			end else if (busy_r) begin
				x_r <= y_r[18] ? x_r - ys : x_r + ys;
				y_r <= y_r[18] ? y_r + xs : y_r - xs;
				z_r <= y_r[18] ? z_r - atan_code(step_r) : z_r + atan_code(step_r);
				step_r <= step_r + 4'h1;
				if (step_r == 4'(`CORDIC_STEPS - 1)) begin
					busy_r <= 1'b0;
					fin_r <= 1'b1;
				end
			end
			if (fin_r) begin
				o_angle <= z_r[14:0];
				o_amp <= (x_r > 19'sh0FFFF) ? 16'hFFFF : x_r[15:0];
			end
		end
	end

	property p_done_bound;
		@(posedge i_clk_sys) disable iff (!i_rst_b) i_start |-> ##17 o_done;
	endproperty
	a_done_bound: assert property (p_done_bound) else $error("cordic did not finish in 17 cycles");
endmodule
`default_nettype wire

/* hw/signal_path_readout.sv */
// Purpose: Signal-path measurement registers of a two-channel position sensor, read over the output pin.
// Assumes: Front-end samples are on the system clock; the pin level comes from a comparator and is asynchronous.
// Notes: Reads are served by pulse-width frames on the pin and never disturb the path.
// How it works
// - temperature readout unsigned, limited to 0..32767
// - temperature calibrated 100 at -40, 12000 at 160
// - per-channel compensated field, signed 16 bits
// - corrected inputs include phase, gain, offset, hysteresis
// - position unsigned, limited to 0..32767
// - output equivalent unsigned, limited to 0..32767
// - amplitude about 1.6 times root sum squares
// - path samples at a fixed rate, 8 kHz unless SAMPLE_CYC is overridden
// - variant routes two field components to channels
// - output curve piecewise linear, 33 setpoints
// - programmer reads registers by modulating output pin
`timescale 1ns/10ps
`default_nettype none
`include "readout_regs.svh"
module signal_path_readout #(
	parameter int SAMPLE_CYC = `SAMPLE_CYC,
	parameter readout_pkg::variant_t VARIANT = readout_pkg::VAR_XY
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire readout_pkg::field_vec_t i_field,
	input wire logic signed [15:0] i_temp_raw,
	input wire readout_pkg::path_cfg_t i_cfg,
	input wire logic [32:0][15:0] i_setpoint,
	input wire logic i_prog_pin,
	output logic o_prog_pin,
	output logic o_prog_pin_oe_b,
	output logic [15:0] o_output_code
);
	import readout_pkg::*;

	if (SAMPLE_CYC < 32) begin : g_chk
		$error("SAMPLE_CYC too short for the angle calculation");
	end

	function automatic logic signed [35:0] sx36(input logic signed [15:0] v);
		sx36 = 36'(v);
	endfunction

	function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
		if (v > 36'sd32767)
			sat16 = 16'sh7FFF;
		else if (v < -36'sd32768)
			sat16 = 16'sh8000;
		else
			sat16 = v[15:0];
	endfunction

	function automatic logic [15:0] clamp_pos(input logic signed [35:0] v);
		if (v > 36'sd32767)
			clamp_pos = `RO_CODE_MAX;
		else if (v < 36'sd0)
			clamp_pos = 16'h0000;
		else
			clamp_pos = v[15:0];
	endfunction

	function automatic logic [16:0] absdiff(input logic signed [15:0] a, input logic signed [15:0] b);
		logic signed [16:0] d;
		d = 17'(a) - 17'(b);
		absdiff = d[16] ? 17'(-d) : d;
	endfunction

	// Sample timing.
	logic [31:0] div_r;
	logic tick_r, start_r;
	logic signed [15:0] a_q, b_q, t_q;
	wire logic sample_tick = (div_r == 32'(SAMPLE_CYC - 1));

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			div_r <= 32'h0;
			tick_r <= 1'b0;
			start_r <= 1'b0;
			a_q <= 16'sh0;
			b_q <= 16'sh0;
			t_q <= 16'sh0;
		end else begin
			div_r <= sample_tick ? 32'h0 : div_r + 32'h1;
			tick_r <= sample_tick;
			start_r <= tick_r;
			if (tick_r) begin
				a_q <= (VARIANT == VAR_YZ) ? i_field.y : i_field.x;
				b_q <= (VARIANT == VAR_XY) ? i_field.y : i_field.z;
				t_q <= i_temp_raw;
			end
		end
	end

	// Compensated and corrected channel values.
	logic [15:0] temp_r, pos_r, outeq_r, mag_r;
	logic signed [15:0] comp_a_r, comp_b_r, corr_a_r, corr_b_r;
	wire logic signed [35:0] temp_lin = ((sx36(t_q) + 36'sd`TEMP_RAW_OFS) * 36'sd`TEMP_SLOPE_NUM) >>> `TEMP_SLOPE_SH;
	wire logic [15:0] temp_nxt = clamp_pos(temp_lin + 36'(`TEMP_CODE_LO));
	wire logic signed [35:0] lin_a = ((sx36(a_q) * sx36(i_cfg.gain_a)) >>> 14) + sx36(i_cfg.offset_a);
	wire logic signed [35:0] lin_b = ((sx36(b_q) * sx36(i_cfg.gain_b) + sx36(a_q) * sx36(i_cfg.phase)) >>> 14)
		+ sx36(i_cfg.offset_b);
	wire logic signed [15:0] cand_a = sat16(lin_a);
	wire logic signed [15:0] cand_b = sat16(lin_b);
	wire logic hold_a = absdiff(cand_a, corr_a_r) < 17'(i_cfg.hyst);
	wire logic hold_b = absdiff(cand_b, corr_b_r) < 17'(i_cfg.hyst);
	wire logic signed [15:0] corr_a_nxt = hold_a ? corr_a_r : cand_a;
	wire logic signed [15:0] corr_b_nxt = hold_b ? corr_b_r : cand_b;

	logic cordic_done;
	logic [14:0] cordic_angle;
	logic [15:0] cordic_amp;

	angle_cordic u_cordic (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_start(start_r),
		.i_a(corr_a_nxt),
		.i_b(corr_b_nxt),
		.o_done(cordic_done),
		.o_angle(cordic_angle),
		.o_amp(cordic_amp)
	);

	// Output characteristic: 32 segments between 33 setpoints.
	wire logic [4:0] seg = cordic_angle[14:10];
	wire logic [9:0] frac = cordic_angle[9:0];
	wire logic [15:0] sp_lo = i_setpoint[seg];
	wire logic [15:0] sp_hi = i_setpoint[6'(seg) + 6'h1];
	wire logic signed [35:0] sp_delta = 36'(sp_hi) - 36'(sp_lo);
	wire logic signed [35:0] curve = $signed(36'(sp_lo)) + ((sp_delta * $signed(36'(frac))) >>> 10);
	wire logic [15:0] outeq_nxt = clamp_pos(curve);

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			temp_r <= `RO_RESET;
			comp_a_r <= `RO_RESET;
			comp_b_r <= `RO_RESET;
			corr_a_r <= `RO_RESET;
			corr_b_r <= `RO_RESET;
			pos_r <= `RO_RESET;
			outeq_r <= `RO_RESET;
			mag_r <= `RO_RESET;
		end else if (cordic_done) begin
			temp_r <= temp_nxt;
			comp_a_r <= a_q;
			comp_b_r <= b_q;
			corr_a_r <= corr_a_nxt;
			corr_b_r <= corr_b_nxt;
			pos_r <= {1'b0, cordic_angle};
			outeq_r <= outeq_nxt;
			mag_r <= cordic_amp;
		end
	end
	assign o_output_code = outeq_r;

	// Pin protocol: low pulses carry bits, a long idle ends the frame, the reply goes out MSB first.
	logic pin_s1_r, pin_s2_r, pin_prev_r, low_seen_r;
	pin_state_t pst_r;
	logic [15:0] cnt_r, tx_r;
	logic [3:0] nbit_r;
	logic [7:0] rx_r;
	wire logic pin_rise = pin_s2_r && !pin_prev_r;
	wire logic frame_ok = (nbit_r == 4'h8) && (rx_r[7:3] == `RO_READ_OPCODE);
	wire logic reply_bit_end = (cnt_r == 16'(`PIN_BIT_CYC - 1));
	logic [15:0] rd_data;

	always_comb begin
		case (rx_r[2:0])
			`RO_IDX_TEMP: rd_data = temp_r;
			`RO_IDX_COMP_A: rd_data = comp_a_r;
			`RO_IDX_COMP_B: rd_data = comp_b_r;
			`RO_IDX_CORR_A: rd_data = corr_a_r;
			`RO_IDX_CORR_B: rd_data = corr_b_r;
			`RO_IDX_POS: rd_data = pos_r;
			`RO_IDX_OUTEQ: rd_data = outeq_r;
			default: rd_data = mag_r;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			pin_prev_r <= 1'b1;
			low_seen_r <= 1'b0;
			pst_r <= PIN_RX;
			cnt_r <= 16'h0;
			tx_r <= 16'h0;
			nbit_r <= 4'h0;
			rx_r <= 8'h0;
		end else begin
			pin_s1_r <= i_prog_pin;
			pin_s2_r <= pin_s1_r;
			pin_prev_r <= pin_s2_r;
			case (pst_r)
				PIN_RX: begin
					// A low that began during a reply ends in a rise here and must not count as a bit.
					if (pin_s2_r != pin_prev_r) begin
						cnt_r <= 16'h0;
						low_seen_r <= !pin_s2_r;
					end else if (cnt_r != 16'hFFFF) begin
						cnt_r <= cnt_r + 16'h1;
					end
					if (pin_rise && low_seen_r && nbit_r != 4'h8) begin
						rx_r <= {rx_r[6:0], cnt_r >= 16'(`PIN_LONG_CYC - 1)};
						nbit_r <= nbit_r + 4'h1;
					end
					if (pin_s2_r && cnt_r == 16'(`PIN_GAP_CYC - 1)) begin
						nbit_r <= 4'h0;
						if (frame_ok) begin
							pst_r <= PIN_REPLY;
							tx_r <= rd_data;
							cnt_r <= 16'h0;
						end
					end
				end
				PIN_REPLY: begin
					cnt_r <= reply_bit_end ? 16'h0 : cnt_r + 16'h1;
					if (reply_bit_end) begin
						tx_r <= {tx_r[14:0], 1'b0};
						nbit_r <= nbit_r + 4'h1;
						if (nbit_r == 4'hF) begin
							pst_r <= PIN_RX;
							nbit_r <= 4'h0;
						end
					end
				end
				default: pst_r <= PIN_RX;
			endcase
		end
	end
	assign o_prog_pin = (pst_r == PIN_REPLY) ? tx_r[15] : 1'b1;
	assign o_prog_pin_oe_b = (pst_r != PIN_REPLY);

	// Helper: cycles since the last sample tick.
	logic [31:0] gap_r;
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b)
			gap_r <= 32'h0;
		else
			gap_r <= tick_r ? 32'h1 : gap_r + 32'h1;
	end

	sequence s_reply_start;
		pst_r == PIN_RX ##1 pst_r == PIN_REPLY;
	endsequence

	property p_temp_range;
		@(posedge i_clk_sys) disable iff (!i_rst_b) temp_r[15] == 1'b0;
	endproperty
	a_temp_range: assert property (p_temp_range) else $error("temperature above 32767");
	property p_temp_cal;
		@(posedge i_clk_sys) disable iff (!i_rst_b) cordic_done && t_q == -16'sd2560 |=> temp_r == 16'h0064;
	endproperty
	a_temp_cal: assert property (p_temp_cal) else $error("temperature code at -40 C is not 100");
	property p_comp_follows;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
			cordic_done |-> gap_r == 32'd18 ##1 (comp_a_r == $past(a_q) && comp_b_r == $past(b_q));
	endproperty
	a_comp_follows: assert property (p_comp_follows) else $error("compensated field not from the sample");
	property p_pos_range;
		@(posedge i_clk_sys) disable iff (!i_rst_b) cordic_done |=> pos_r[15] == 1'b0 && outeq_r <= 16'h7FFF;
	endproperty
	a_pos_range: assert property (p_pos_range) else $error("position or output code out of range");
	property p_outeq_node;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
			cordic_done && frac == 10'h0 && sp_lo <= 16'h7FFF |=> outeq_r == $past(sp_lo);
	endproperty
	a_outeq_node: assert property (p_outeq_node) else $error("output code misses setpoint");
	property p_tick_period;
		@(posedge i_clk_sys) disable iff (!i_rst_b) tick_r |-> gap_r == 32'(SAMPLE_CYC) || $past(!i_rst_b, 2);
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("sample period wrong");
	property p_one_update;
		@(posedge i_clk_sys) disable iff (!i_rst_b) !cordic_done |=> $stable(pos_r) && $stable(mag_r);
	endproperty
	a_one_update: assert property (p_one_update) else $error("register changed outside update");
	property p_reply_drive;
		@(posedge i_clk_sys) disable iff (!i_rst_b) s_reply_start |-> !o_prog_pin_oe_b [*8];
	endproperty
	a_reply_drive: assert property (p_reply_drive) else $error("pin released during reply");
	property p_variant_route;
		@(posedge i_clk_sys) disable iff (!i_rst_b) tick_r |=> b_q == $past(VARIANT == VAR_XY ? i_field.y : i_field.z);
	endproperty
	a_variant_route: assert property (p_variant_route) else $error("second channel wrongly routed");
endmodule
`default_nettype wire

/* sim/pin_programmer.sv */
// Purpose: Programmer model that reads registers by pulse-width frames on the output pin.
// Assumes: Pin idles high through a pull-up when nobody drives it.
// Notes: The reply bits are sampled in the middle of each bit time.
`timescale 1ns/10ps
`default_nettype none
module pin_programmer (
	input wire logic i_clk_sys,
	input wire logic i_line,
	input wire logic i_oe_b,
	output logic o_drive_en,
	output logic o_drive_val
);
	initial begin
		o_drive_en = 1'b0;
		o_drive_val = 1'b1;
	end

	// Sends one command byte MSB first, then listens for a 16-bit reply.
	task automatic xfer(input logic [7:0] cmd, output logic got, output logic [15:0] data);
		int n;
		got = 1'b0;
		data = 16'h0000;
		for (int i = 7; i >= 0; i--) begin
			@(negedge i_clk_sys);
			o_drive_en = 1'b1;
			o_drive_val = 1'b0;
			repeat (cmd[i] ? 2200 : 500) @(negedge i_clk_sys);
			o_drive_val = 1'b1;
			repeat (300) @(negedge i_clk_sys);
		end
		// The pin is let go so the device can answer on it.
		o_drive_en = 1'b0;
		n = 0;
		while (i_oe_b !== 1'b0 && n < 4600) begin
			@(negedge i_clk_sys);
			n++;
		end
		if (i_oe_b === 1'b0) begin
			got = 1'b1;
			repeat (1000) @(negedge i_clk_sys);
			for (int b = 0; b < 16; b++) begin
				data = {data[14:0], i_line};
				repeat (2000) @(negedge i_clk_sys);
			end
		end
	endtask
endmodule
`default_nettype wire

/* sim/signal_path_readout_tb.sv */
// Purpose: Self-checking bench of the signal-path readout.
// Assumes: Short sample period of 64 cycles; flat output curve so the output code is known.
// Notes: Output updates are checked against a queue while pin reads run alongside.
`timescale 1ns/10ps
`default_nettype none
`include "readout_regs.svh"
module signal_path_readout_tb;
	import readout_pkg::*;
	localparam int SCYC = 64;
	logic i_clk_sys = 1'b0;
	logic i_rst_b = 1'b0;
	field_vec_t i_field = '0;
	logic signed [15:0] i_temp_raw = 16'sh2800;
	path_cfg_t i_cfg = '{16'sh4000, 16'sh4000, 16'sh0000, 16'sh0000, 16'sh0000, 16'h0000};
	logic [32:0][15:0] i_setpoint;
	logic o_prog_pin;
	logic o_prog_pin_oe_b;
	logic [15:0] o_output_code;
	logic drv_en;
	logic drv_val;
	wire pin_line;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	int last_upd = 0;
	int n_upd = 0;
	bit have_last = 0;
	logic [31:0] st = 32'd36;
	logic [15:0] sp_cur;
	logic [15:0] drv_last = 16'h0000;
	logic [15:0] mon_last = 16'h0000;
	logic [15:0] exp_q[$];
	logic got;
	logic [15:0] data;

	always #5 i_clk_sys = ~i_clk_sys;

	// The line is pulled up when neither side drives it.
	assign pin_line = !o_prog_pin_oe_b ? o_prog_pin : (drv_en ? drv_val : 1'b1);

	signal_path_readout #(.SAMPLE_CYC(SCYC)) i_signal_path_readout (
		.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_field(i_field), .i_temp_raw(i_temp_raw),
		.i_cfg(i_cfg), .i_setpoint(i_setpoint), .i_prog_pin(pin_line), .o_prog_pin(o_prog_pin),
		.o_prog_pin_oe_b(o_prog_pin_oe_b), .o_output_code(o_output_code)
	);

	pin_programmer i_pin_programmer (
		.i_clk_sys(i_clk_sys), .i_line(pin_line), .i_oe_b(o_prog_pin_oe_b),
		.o_drive_en(drv_en), .o_drive_val(drv_val)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		if (err_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// A flat curve makes the output code equal the setpoint at any angle.
	initial begin
		st = xs(st);
		sp_cur = {1'b0, st[14:0]} | 16'h0001;
		i_setpoint = {33{sp_cur}};
		exp_q.push_back(sp_cur);
	end

	always @(negedge i_clk_sys) begin
		st = xs(st);
		i_field <= {st[15:0], st[31:16], st[23:8]};
		if (i_rst_b && o_output_code !== drv_last) begin
			drv_last = o_output_code;
			st = xs(st);
			if ({1'b0, st[14:0]} === sp_cur)
				sp_cur = {1'b0, st[14:0]} ^ 16'h0001;
			else
				sp_cur = {1'b0, st[14:0]};
			i_setpoint <= {33{sp_cur}};
			exp_q.push_back(sp_cur);
		end
	end

	// The monitor samples at the falling edge, where the registered output has settled.
	always @(negedge i_clk_sys) begin
		if (!i_rst_b) begin
			have_last = 0;
			mon_last = 16'h0000;
		end else if (o_output_code !== mon_last) begin
			mon_last = o_output_code;
			if (have_last)
				check(16'(cyc - last_upd), 16'(SCYC));
			if (exp_q.size() == 0)
				check(16'h0000, 16'h0001);
			else
				check(o_output_code, exp_q.pop_front());
			last_upd = cyc;
			have_last = 1;
			n_upd++;
		end
		cyc++;
	end

	initial begin
		repeat (2) @(negedge i_clk_sys);
		check(o_output_code, `RO_RESET);
		check({15'h0000, o_prog_pin_oe_b}, 16'h0001);
		i_rst_b = 1'b1;
		i_pin_programmer.xfer({`RO_READ_OPCODE, `RO_IDX_TEMP}, got, data);
		check({15'h0000, got}, 16'h0001);
		check(data, 16'h2EE0);
		check({15'h0000, data[15]}, 16'h0000);
		// A junction temperature of -40 C lets the calibration assertion see its case.
		i_temp_raw = -16'sd2560;
		i_pin_programmer.xfer({5'h14, `RO_IDX_MAG}, got, data);
		check({15'h0000, got}, 16'h0000);
		check({15'h0000, n_upd >= 500}, 16'h0001);
		stop_test();
	end
endmodule
`default_nettype wire
